//--- hdl/qrsp_pkg.sv
package qrsp_pkg;

    // ==========================================================
    // Geometry
    localparam int DATA_MAX = 36;
    localparam int ADDR_W = 19;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int IMP_W = 6;
    localparam int WIDE_W = 36;
    localparam int NARROW_W = 18;

    // ==========================================================
    // Timing
    localparam int SYS_CLK_MHZ = 100;
    localparam int CAL_PERIOD_NS = 10000;
    localparam int CAL_CYCLES = (CAL_PERIOD_NS * SYS_CLK_MHZ) / 1000;
    localparam int SETTLE_CYCLES = 1024;
    localparam int STRAP_WAIT = 4;

    // ==========================================================
    // Reset values
    localparam logic [IMP_W-1:0] IMP_RESET = 6'h20;
    localparam logic [10:0] SETTLE_RESET = 11'h000;
    localparam logic [13:0] CAL_RESET = 14'h0000;

    // ==========================================================
    // Burst state machines, one-hot
    typedef enum logic [2:0] {
        WR_IDLE = 3'h1,
        WR_HALF0 = 3'h2,
        WR_HALF1 = 3'h4
    } qrsp_wr_e;

    typedef enum logic [2:0] {
        RD_IDLE = 3'h1,
        RD_HALF0 = 3'h2,
        RD_HALF1 = 3'h4
    } qrsp_rd_e;

    // One input beat: data plus active-low lane_mask_0..3
    typedef struct packed {
        logic [DATA_MAX-1:0] data;
        logic [LANES-1:0] laneMask_n;
    } qrsp_beat_s;

endpackage

//--- hdl/qrsp_sync.sv
`timescale 1ns/10ps
module qrsp_sync
    import qrsp_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Crossing signal
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] value
);

    // ==========================================================
    // Three stages; value moves once stages two and three agree
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            value <= '0;
        end
        else
        begin
            s1 <= async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
                value <= s3;
            end
        end
    end

endmodule

//--- hdl/qrsp_core.sv
`timescale 1ns/10ps
module qrsp_core
    import qrsp_pkg::*;
#(
    parameter int AW = ADDR_W
)
(
    // Link clock
    input wire logic clk,
    // Two write ports with lane enables
    input wire logic [1:0] wrEn,
    input wire logic [1:0][AW-1:0] wrAddr,
    input wire logic [1:0][DATA_MAX-1:0] wrData,
    input wire logic [1:0][LANES-1:0] wrLane,
    // Two registered read ports
    input wire logic [1:0][AW-1:0] rdAddr,
    output logic [1:0][DATA_MAX-1:0] rdData
);

    // ==========================================================
    // Storage array
    logic [DATA_MAX-1:0] mem [0:(1<<AW)-1];

    // Lane-masked writes; one process owns the array
    always_ff @(posedge clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (wrEn[p] && wrLane[p][l])
                begin
                    mem[wrAddr[p]][l*LANE_W +: LANE_W] <= wrData[p][l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Synchronous read, one generate branch per port
    for (genvar p = 0; p < 2; p++)
    begin : gPort
        always_ff @(posedge clk)
        begin
            rdData[p] <= mem[rdAddr[p]];
        end
    end

endmodule

//--- hdl/qrsp_port.sv
`timescale 1ns/10ps
module qrsp_port
    import qrsp_pkg::*;
#(
    parameter int DATA_W = WIDE_W
)
(
    // System clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Link clock (input clock pair, rise of K)
    input wire logic linkClk,
    // Commands and shared address bus halves
    input wire logic storeReq_n,
    input wire logic fetchSel_n,
    input wire logic [ADDR_W-1:0] readAddr,
    input wire logic [ADDR_W-1:0] writeAddr,
    // Write beats at K and complement-K rises
    input wire qrsp_beat_s wrBeat0,
    input wire qrsp_beat_s wrBeat1,
    // Output clock pair held-high level
    input wire logic outClkHeldPin,
    // Impedance comparator code from impedance_sense_pin
    input wire logic [IMP_W-1:0] impedanceSense,
    // Read beats and output enable
    output logic [DATA_MAX-1:0] rdBeat0,
    output logic [DATA_MAX-1:0] rdBeat1,
    output logic rdValid,
    // Status
    output logic singleClockMode,
    output logic [IMP_W-1:0] impedanceCode,
    output logic impedanceSettled
);

    // ==========================================================
    // State records
    typedef struct packed {
        logic [13:0] calCnt;
        logic reqTog;
        logic [IMP_W-1:0] code;
    } qrsp_sys_s;

    typedef struct packed {
        qrsp_wr_e wrState;
        logic [ADDR_W-1:0] wrAddr;
        qrsp_rd_e rdState;
        logic [ADDR_W-1:0] rdAddr;
        logic [DATA_MAX-1:0] q0;
        logic [DATA_MAX-1:0] q1;
        logic qValid;
        logic [2:0] strapWait;
        logic outClkHeld;
        logic [IMP_W-1:0] impCode;
        logic impAck;
        logic [10:0] settleCnt;
        logic settled;
    } qrsp_link_s;

    qrsp_sys_s sys;
    qrsp_sys_s next_sys;
    qrsp_link_s lnk;
    qrsp_link_s next_lnk;

    logic linkRst_n;
    logic ackSeen;
    logic reqSeen;
    logic heldSeen;
    logic [IMP_W-1:0] senseSeen;
    logic [LANES-1:0] laneCfg;
    logic wrTake;
    logic rdTake;
    logic [1:0] memWrEn;
    logic [1:0][ADDR_W-1:0] memWrAddr;
    logic [1:0][DATA_MAX-1:0] memWrData;
    logic [1:0][LANES-1:0] memWrLane;
    logic [1:0][ADDR_W-1:0] memRdAddr;
    logic [1:0][DATA_MAX-1:0] memRdData;

    // Linear 2-bit burst step within an aligned group of four
    function automatic logic [ADDR_W-1:0] burstAddr(input logic [ADDR_W-1:0] base, input logic [1:0] step);
        burstAddr = {base[ADDR_W-1:2], 2'(base[1:0] + step)};
    endfunction

    // ==========================================================
    // Crossings
    qrsp_sync #(.WIDTH(1)) uRstSync (
        .clk(linkClk),
        .rst_n(1'b1),
        .async(reset_n),
        .value(linkRst_n)
    );

    qrsp_sync #(.WIDTH(1)) uReqSync (
        .clk(linkClk),
        .rst_n(linkRst_n),
        .async(sys.reqTog),
        .value(reqSeen)
    );

    qrsp_sync #(.WIDTH(1)) uHeldSync (
        .clk(linkClk),
        .rst_n(linkRst_n),
        .async(outClkHeldPin),
        .value(heldSeen)
    );

    qrsp_sync #(.WIDTH(1)) uAckSync (
        .clk(clk_sys),
        .rst_n(reset_n),
        .async(lnk.impAck),
        .value(ackSeen)
    );

    qrsp_sync #(.WIDTH(IMP_W)) uSenseSync (
        .clk(clk_sys),
        .rst_n(reset_n),
        .async(impedanceSense),
        .value(senseSeen)
    );

    // ==========================================================
    // Storage
    qrsp_core #(.AW(ADDR_W)) uCore (
        .clk(linkClk),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .wrLane(memWrLane),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    // ==========================================================
    // System side: periodic calibration sample, toggle handshake
    always_comb
    begin
        next_sys = sys;
        if (sys.calCnt != 14'(CAL_CYCLES - 1))
        begin
            next_sys.calCnt = 14'(sys.calCnt + 14'h0001);
        end
        else if (ackSeen == sys.reqTog)
        begin
            next_sys.calCnt = CAL_RESET;
            next_sys.code = senseSeen; // Held stable until acknowledged
            next_sys.reqTog = ~sys.reqTog;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sys <= '{calCnt: CAL_RESET, reqTog: 1'b0, code: IMP_RESET};
        end
        else
        begin
            sys <= next_sys;
        end
    end

    // ==========================================================
    // Link side: independent write and read machines
    assign laneCfg = (DATA_W == NARROW_W) ? 4'h3 : 4'hf;
    assign wrTake = !storeReq_n && (lnk.wrState != WR_HALF0);
    assign rdTake = !fetchSel_n && (lnk.rdState != RD_HALF0);

    // Write beats go to storage only inside an accepted burst
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            memWrEn[p] = (lnk.wrState != WR_IDLE);
            memWrAddr[p] = burstAddr(lnk.wrAddr, {lnk.wrState == WR_HALF1, 1'(p)});
        end
        memWrData[0] = wrBeat0.data;
        memWrData[1] = wrBeat1.data;
        memWrLane[0] = ~wrBeat0.laneMask_n & laneCfg;
        memWrLane[1] = ~wrBeat1.laneMask_n & laneCfg;
        for (int p = 0; p < 2; p++)
        begin
            memRdAddr[p] = rdTake ? burstAddr(readAddr, 2'(p)) : burstAddr(lnk.rdAddr, 2'(p + 2));
        end
    end

    always_comb
    begin
        next_lnk = lnk;
        // Write machine
        case (lnk.wrState)
            WR_IDLE, WR_HALF1:
            begin
                next_lnk.wrState = wrTake ? WR_HALF0 : WR_IDLE;
            end
            WR_HALF0:
            begin
                next_lnk.wrState = WR_HALF1;
            end
            default:
            begin
                next_lnk.wrState = WR_IDLE;
            end
        endcase
        if (wrTake)
        begin
            next_lnk.wrAddr = writeAddr;
        end
        // Read machine, separate from writes
        case (lnk.rdState)
            RD_IDLE, RD_HALF1:
            begin
                next_lnk.rdState = rdTake ? RD_HALF0 : RD_IDLE;
            end
            RD_HALF0:
            begin
                next_lnk.rdState = RD_HALF1;
            end
            default:
            begin
                next_lnk.rdState = RD_IDLE;
            end
        endcase
        if (rdTake)
        begin
            next_lnk.rdAddr = readAddr;
        end
        // Output launch one input edge after each half
        next_lnk.qValid = (lnk.rdState != RD_IDLE);
        if (lnk.rdState != RD_IDLE)
        begin
            next_lnk.q0 = memRdData[0] & DATA_MAX'((64'h1 << DATA_W) - 64'h1);
            next_lnk.q1 = memRdData[1] & DATA_MAX'((64'h1 << DATA_W) - 64'h1);
        end
        // Single-clock strap taken once syncs have settled
        if (lnk.strapWait != 3'(STRAP_WAIT + 1))
        begin
            next_lnk.strapWait = 3'(lnk.strapWait + 3'h1);
            if (lnk.strapWait == 3'(STRAP_WAIT)) // Pin sync leaves reset with the link
            begin
                next_lnk.outClkHeld = heldSeen;
            end
        end
        // Impedance update only while outputs stay disabled
        if ((reqSeen != lnk.impAck) && !next_lnk.qValid && !lnk.qValid)
        begin
            next_lnk.impCode = sys.code;
            next_lnk.impAck = reqSeen;
        end
        // Count non-read cycles after power-up
        if (!lnk.settled)
        begin
            if (rdTake || lnk.rdState != RD_IDLE)
            begin
                next_lnk.settleCnt = SETTLE_RESET;
            end
            else
            begin
                next_lnk.settleCnt = 11'(lnk.settleCnt + 11'h001);
                next_lnk.settled = (lnk.settleCnt == 11'(SETTLE_CYCLES - 1));
            end
        end
    end

    // Link state register; a stopped link clock freezes everything
    always_ff @(posedge linkClk)
    begin
        if (!linkRst_n)
        begin
            lnk <= '0;
            lnk.wrState <= WR_IDLE;
            lnk.rdState <= RD_IDLE;
            lnk.impCode <= IMP_RESET;
        end
        else
        begin
            lnk <= next_lnk;
        end
    end

    // Outputs straight from flip-flops
    assign rdBeat0 = lnk.q0;
    assign rdBeat1 = lnk.q1;
    assign rdValid = lnk.qValid;
    assign singleClockMode = lnk.outClkHeld;
    assign impedanceCode = lnk.impCode;
    assign impedanceSettled = lnk.settled;

    // ==========================================================
    // Checks
    wr_accept_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (!storeReq_n && lnk.wrState == WR_IDLE) |=> (lnk.wrState == WR_HALF0 && lnk.wrAddr == $past(writeAddr)))
        else $error("write command not accepted");

    wr_four_beats_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        wrTake |=> (memWrEn == 2'h3 && lnk.wrState == WR_HALF0) ##1 (memWrEn == 2'h3 && lnk.wrState == WR_HALF1))
        else $error("write burst not four beats");

    wr_ignore_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (lnk.wrState == WR_IDLE) |-> (memWrEn == 2'h0))
        else $error("write outside burst");

    lane_gate_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (DATA_W == WIDE_W && memWrEn == 2'h3) |-> (memWrLane == {~wrBeat1.laneMask_n, ~wrBeat0.laneMask_n}))
        else $error("lane mask not applied");

    narrow_lanes_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (DATA_W == NARROW_W) |-> (memWrLane[0][3:2] == 2'h0 && memWrLane[1][3:2] == 2'h0))
        else $error("narrow config wrote upper lanes");

    rd_latency_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (!fetchSel_n && lnk.rdState == RD_IDLE) |=> !lnk.qValid ##1 lnk.qValid[*2])
        else $error("read data timing wrong");

    burst_ignore_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (lnk.rdState == RD_HALF0) |=> (lnk.rdState == RD_HALF1 && lnk.rdAddr == $past(lnk.rdAddr)))
        else $error("read burst interrupted");

    deselect_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (lnk.rdState == RD_HALF1 && fetchSel_n) |=> (lnk.rdState == RD_IDLE && lnk.qValid) ##1 !lnk.qValid)
        else $error("deselect truncated burst");

    imp_quiet_a: assert property (
        @(posedge linkClk) disable iff (!linkRst_n)
        (lnk.impCode != $past(lnk.impCode)) |-> (!lnk.qValid && !$past(lnk.qValid)))
        else $error("impedance changed while driving");

endmodule

//--- tb/qrsp_ctrl_model.sv
`timescale 1ns/10ps
module qrsp_ctrl_model
    import qrsp_pkg::*;
(
    // Link clock
    input wire logic linkClk,
    // Commands and shared address bus halves
    output logic storeReq_n,
    output logic fetchSel_n,
    output logic [ADDR_W-1:0] readAddr,
    output logic [ADDR_W-1:0] writeAddr,
    // Write beats
    output qrsp_beat_s wrBeat0,
    output qrsp_beat_s wrBeat1
);
    // ==========================================================
    // Idle bus at time zero
    initial
    begin
        storeReq_n = 1'b1;
        fetchSel_n = 1'b1;
        readAddr = '0;
        writeAddr = '0;
        wrBeat0 = '0;
        wrBeat1 = '1;
    end

    // ==========================================================
    // Write burst; next command may follow in the step it returns
    task automatic store(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b,
        input logic [3:0][DATA_MAX-1:0] w, input logic [LANES-1:0] m, input logic bad);
        storeReq_n = 1'b0;
        writeAddr = a;
        @(posedge linkClk);
        #1;
        storeReq_n = ~bad;
        writeAddr = b;
        wrBeat0 = '{w[0], m};
        wrBeat1 = '{w[1], m};
        @(posedge linkClk);
        #1;
        if (bad)
            storeReq_n = 1'b1;
        wrBeat0 = '{w[2], m};
        wrBeat1 = '{w[3], m};
    endtask

    // Released lines toggle so stale beats never look valid
    task automatic rest(input int n);
        repeat (n)
        begin
            @(posedge linkClk);
            #1;
            writeAddr = ~writeAddr;
            wrBeat0 = ~wrBeat0;
            wrBeat1 = ~wrBeat1;
        end
    endtask

    // Read command, then the next command slot
    task automatic fetch(input logic [ADDR_W-1:0] a);
        fetchSel_n = 1'b0;
        readAddr = a;
        @(posedge linkClk);
        #1;
        fetchSel_n = 1'b1;
        readAddr = ~a;
        @(posedge linkClk);
        #1;
    endtask
endmodule

//--- tb/qrsp_port_tb.sv
`timescale 1ns/10ps
module qrsp_port_tb
    import qrsp_pkg::*;
;
    // ==========================================================
    // Signals
    logic clk_sys = 1'b0;
    logic linkClk = 1'b0;
    logic reset_n = 1'b0;
    logic heldPin = 1'b0;
    logic linkRun = 1'b1;
    logic storeReq_n, fetchSel_n, rdValid, singleClockMode, impedanceSettled;
    logic [ADDR_W-1:0] readAddr, writeAddr;
    qrsp_beat_s wrBeat0, wrBeat1;
    logic [IMP_W-1:0] impedanceSense, impedanceCode;
    logic [DATA_MAX-1:0] rdBeat0, rdBeat1;
    logic [DATA_MAX-1:0] nrwBeat0, nrwBeat1;
    logic nrwValid;
    localparam logic [DATA_MAX-1:0] NARROW_MASK = 36'h3ffff;
    logic [DATA_MAX-1:0] mem [int];
    logic [2*DATA_MAX-1:0] notes [$];
    logic [ADDR_W-1:0] addrs [4];
    logic [3:0] pat [6] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h3, 4'hf};
    int nFail = 0;
    int totalChecks = 0;

    // Clocks, unrelated in phase
    always #5 clk_sys = ~clk_sys;
    always #6
        if (linkRun)
            linkClk = ~linkClk;

    // ==========================================================
    // Instances
    qrsp_ctrl_model qrsp_ctrl_model_i (.linkClk(linkClk), .storeReq_n(storeReq_n), .fetchSel_n(fetchSel_n),
        .readAddr(readAddr), .writeAddr(writeAddr), .wrBeat0(wrBeat0), .wrBeat1(wrBeat1));

    qrsp_port #(.DATA_W(WIDE_W)) qrsp_port_i (.clk_sys(clk_sys), .reset_n(reset_n), .linkClk(linkClk),
        .storeReq_n(storeReq_n), .fetchSel_n(fetchSel_n), .readAddr(readAddr), .writeAddr(writeAddr),
        .wrBeat0(wrBeat0), .wrBeat1(wrBeat1), .outClkHeldPin(heldPin), .impedanceSense(impedanceSense),
        .rdBeat0(rdBeat0), .rdBeat1(rdBeat1), .rdValid(rdValid), .singleClockMode(singleClockMode),
        .impedanceCode(impedanceCode), .impedanceSettled(impedanceSettled));

    // Narrow configuration on the same bus
    qrsp_port #(.DATA_W(NARROW_W)) qrsp_port_narrow_i (.clk_sys(clk_sys), .reset_n(reset_n), .linkClk(linkClk),
        .storeReq_n(storeReq_n), .fetchSel_n(fetchSel_n), .readAddr(readAddr), .writeAddr(writeAddr),
        .wrBeat0(wrBeat0), .wrBeat1(wrBeat1), .outClkHeldPin(heldPin), .impedanceSense(impedanceSense),
        .rdBeat0(nrwBeat0), .rdBeat1(nrwBeat1), .rdValid(nrwValid), .singleClockMode(),
        .impedanceCode(), .impedanceSettled());

    // ==========================================================
    // Helpers
    function automatic logic [ADDR_W-1:0] wordAt(input logic [ADDR_W-1:0] a, input int k);
        return {a[ADDR_W-1:2], a[1:0] + 2'(k)};
    endfunction

    task automatic check(input string what, input logic [DATA_MAX-1:0] seen, input logic [DATA_MAX-1:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            nFail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reportAndStop;
        if (nFail == 0 && totalChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Write burst with masked expectation update
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m, input logic bad);
        logic [3:0][DATA_MAX-1:0] w;
        for (int k = 0; k < 4; k++)
        begin
            w[k] = DATA_MAX'({$urandom, $urandom});
            for (int i = 0; i < LANES; i++)
                if (!m[i])
                    mem[wordAt(a, k)][LANE_W*i +: LANE_W] = w[k][LANE_W*i +: LANE_W];
        end
        qrsp_ctrl_model_i.store(a, bad ? addrs[3] : ~a, w, m, bad);
    endtask

    // Read burst; notes the two expected word pairs
    task automatic rd(input logic [ADDR_W-1:0] a);
        for (int k = 0; k < 4; k += 2)
            notes.push_back({mem[wordAt(a, k + 1)], mem[wordAt(a, k)]});
        qrsp_ctrl_model_i.fetch(a);
    endtask

    // ==========================================================
    // Read monitor, oldest note per valid cycle
    always @(negedge linkClk)
    begin
        if (reset_n === 1'b1 && rdValid !== 1'b0)
        begin
            if (notes.size() == 0)
                check("spare read beat", DATA_MAX'(rdValid), '0);
            else
            begin
                check("read word even", rdBeat0, notes[0][DATA_MAX-1:0]);
                check("read word odd", rdBeat1, notes[0][2*DATA_MAX-1:DATA_MAX]);
                check("narrow valid", DATA_MAX'(nrwValid), 36'h1);
                check("narrow word even", nrwBeat0, notes[0][DATA_MAX-1:0] & NARROW_MASK);
                check("narrow word odd", nrwBeat1, notes[0][2*DATA_MAX-1:DATA_MAX] & NARROW_MASK);
                void'(notes.pop_front());
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'he91a));
        impedanceSense = IMP_W'($urandom);
        repeat (12) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        repeat (10) @(posedge linkClk);
        #1;
        check("clock mode", DATA_MAX'(singleClockMode), '0);
        check("settled early", DATA_MAX'(impedanceSettled), '0);
        // Back-to-back unaligned full writes, then back-to-back reads
        for (int k = 0; k < 4; k++)
        begin
            addrs[k] = ADDR_W'($urandom);
            wr(addrs[k], 4'h0, 1'b0);
        end
        qrsp_ctrl_model_i.rest(2);
        for (int k = 0; k < 4; k++)
            rd(addrs[k]);
        // Six lane patterns, with a read running alongside
        foreach (pat[p])
        begin
            fork
                wr(addrs[0], pat[p], 1'b0);
                rd(addrs[1]);
            join
            qrsp_ctrl_model_i.rest(1);
            rd(addrs[0]);
        end
        // Intruding command inside a burst
        wr(addrs[2], 4'h0, 1'b1);
        qrsp_ctrl_model_i.rest(2);
        rd(addrs[3]);
        // Link clock held still mid-burst; outputs must wait
        linkRun = 1'b0;
        #100;
        linkRun = 1'b1;
        rd(addrs[2]);
        // Quiet period for impedance update
        impedanceSense = IMP_W'($urandom);
        repeat (2200) @(posedge clk_sys);
        #1;
        check("impedance settled", DATA_MAX'(impedanceSettled), 36'h1);
        check("impedance code", DATA_MAX'(impedanceCode), DATA_MAX'(impedanceSense));
        // Mid-run reset with the output clocks held high
        heldPin = 1'b1;
        reset_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        repeat (10) @(posedge linkClk);
        #1;
        check("clock mode held", DATA_MAX'(singleClockMode), 36'h1);
        check("impedance reset", DATA_MAX'(impedanceCode), DATA_MAX'(IMP_RESET));
        check("settled reset", DATA_MAX'(impedanceSettled), '0);
        rd(addrs[1]);
        qrsp_ctrl_model_i.rest(3);
        check("reads left", DATA_MAX'(notes.size()), '0);
        reportAndStop();
    end

    // Watchdog against a hang
    initial
    begin
        #300000;
        nFail++;
        reportAndStop();
    end
endmodule
